// [shared/load_prot_pkg.sv]
// Constants and types shared by the load protection supervisor and its trip filter.
// Assumes one clock domain; all sizes of measured quantities are set by module parameters.
package load_prot_pkg;

	typedef enum logic [3:0] {
		ST_DISABLED = 4'h1,
		ST_ENABLED  = 4'h2,
		ST_SOFT     = 4'h4,
		ST_HARD     = 4'h8
	} status_t;

	// Trip counts and threshold scaling in percent of full scale
	localparam int TRIP_SAMPLES_DEF = 4;
	localparam int TRIP_LIMIT_PCT   = 110;
	localparam int UV_MIN_PCT       = 5;

	// Threshold selector codes
	localparam logic [1:0] SEL_OV = 2'h0;
	localparam logic [1:0] SEL_UV = 2'h1;
	localparam logic [1:0] SEL_OC = 2'h2;
	localparam logic [1:0] SEL_OP = 2'h3;

	// Lock source ranks, higher value wins
	localparam logic [1:0] RANK_NONE  = 2'h0;
	localparam logic [1:0] RANK_PANEL = 2'h1;
	localparam logic [1:0] RANK_SCPI  = 2'h2;
	localparam logic [1:0] RANK_DIN   = 2'h3;

	// Alarm bit positions
	localparam int AL_OV  = 0;
	localparam int AL_UV  = 1;
	localparam int AL_OC  = 2;
	localparam int AL_OP  = 3;
	localparam int AL_ILK = 4;
	localparam int AL_TH  = 5;
	localparam int AL_N   = 6;

	// Values after reset
	localparam logic       ILK_EN_RST  = 1'b0;
	localparam logic [3:0] REG_LED_RST = 4'h1;
	localparam logic [2:0] SYNC_RST    = 3'h0;

endpackage

// [testbench/load_fault_protection_supervisor_test.sv]
// Self-checking bench for the load fault supervisor.
// Assumes the partner model drives commands and pins; the bench drives measurements.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
	$display("BAD %s exp %0h got %0h", n, e, g); end end
module load_fault_protection_supervisor_test;
	import load_prot_pkg::*;
	localparam int W = 16;
	localparam int N = 4;
	localparam int FS = 30000;
	localparam logic [W-1:0] TOP = W'(FS * TRIP_LIMIT_PCT / 100);
	localparam logic [W-1:0] UVMIN = W'((FS * UV_MIN_PCT + 99) / 100);
	localparam logic [3:0] K_START = 4'h1;
	localparam logic [3:0] K_STOP = 4'h2;
	localparam logic [3:0] K_CLEAR = 4'h4;
	localparam logic [3:0] K_RESTORE = 4'h8;
	typedef struct packed {
		status_t         st;
		logic            sw;
		logic [AL_N-1:0] al;
	} note_t;
	logic            mclk, rst_b, sample_en, ilk_pin, therm_pin, lock_pin;
	logic            cmd_start, cmd_stop, cmd_clear, cmd_panel, factory_restore;
	logic            thr_wr, ilk_en_wr, ilk_en_val, lock_req, unlock_req;
	logic            input_switch_on, ov_alarm, uv_alarm, oc_alarm, op_alarm;
	logic            ilk_alarm, therm_alarm, lock_led, ilk_enabled;
	logic [1:0]      thr_sel, lock_src, lock_rank, reg_code;
	logic [3:0]      reg_state_in, reg_led;
	logic [W-1:0]    v_meas, i_meas, p_meas, thr_val;
	logic [W-1:0]    ovt_level, uvt_level, oct_level, opt_level;
	logic [AL_N-1:0] al;
	status_t         status, last_st;
	note_t           q[$];
	note_t           nt;
	int              num_errors = 0;
	int              checks = 0;

	load_fault_supervisor #(.W(W), .N_TRIP(N), .V_FS(FS), .I_FS(FS), .P_FS(FS)) dut (
		.mclk, .rst_b, .sample_en, .v_meas, .i_meas, .p_meas, .reg_state_in,
		.ilk_pin, .therm_pin, .lock_pin, .cmd_start, .cmd_stop, .cmd_clear, .cmd_panel,
		.factory_restore, .thr_wr, .thr_sel, .thr_val, .ilk_en_wr, .ilk_en_val,
		.lock_req, .unlock_req, .lock_src, .input_switch_on, .status, .ov_alarm,
		.uv_alarm, .oc_alarm, .op_alarm, .ilk_alarm, .therm_alarm, .lock_led,
		.lock_rank, .ilk_enabled, .reg_led, .reg_code, .ovt_level, .uvt_level,
		.oct_level, .opt_level);
	load_partner_model #(.W(W)) pm (
		.mclk, .cmd_start, .cmd_stop, .cmd_clear, .cmd_panel, .factory_restore,
		.thr_wr, .thr_sel, .thr_val, .ilk_en_wr, .ilk_en_val, .lock_req,
		.unlock_req, .lock_src, .ilk_pin, .therm_pin, .lock_pin);

	always_comb begin
		al = '0;
		al[AL_OV] = ov_alarm;
		al[AL_UV] = uv_alarm;
		al[AL_OC] = oc_alarm;
		al[AL_OP] = op_alarm;
		al[AL_ILK] = ilk_alarm;
		al[AL_TH] = therm_alarm;
	end

	// Every status change must match the oldest note left by the driver
	always @(negedge mclk) begin
		if (!rst_b) begin
			last_st = status;
		end else if (status !== last_st) begin
			last_st = status;
			if (q.size() == 0) begin
				num_errors++;
				$display("BAD status exp none got %0h", status);
			end else begin
				nt = q.pop_front();
				`CHK("status", nt.st, status)
				`CHK("switch", nt.sw, input_switch_on)
				`CHK("alarms", nt.al, al)
			end
		end
	end

	task automatic give_verdict();
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic idle(input int n);
		repeat (n) @(negedge mclk);
	endtask

	task automatic ev(input status_t s, input logic w, input int b);
		note_t x;
		x.st = s;
		x.sw = w;
		x.al = (b < 0) ? '0 : AL_N'(1) << b;
		q.push_back(x);
	endtask

	task automatic drain();
		for (int i = 0; i < 20 && q.size() != 0; i++) @(negedge mclk);
		if (q.size() != 0) begin
			num_errors++;
			$display("BAD wait exp %0h got %0h", q[0].st, status);
			give_verdict();
		end
	endtask

	task automatic act(input logic [3:0] k, input logic pnl, input status_t s, input logic w,
			input int b);
		ev(s, w, b);
		pm.press(k, pnl);
		drain();
	endtask

	// A refused command leaves the status where it was
	task automatic nop(input logic [3:0] k, input logic pnl, input status_t s);
		pm.press(k, pnl);
		idle(3);
		`CHK("refused", s, status)
	endtask

	task automatic samp(input int k, input logic [W-1:0] val, input int n);
		repeat (n) begin
			@(negedge mclk);
			sample_en = 1'b1;
			v_meas = (k == 0) ? val : 16'h2710;
			i_meas = (k == 1) ? val : 16'h03E8;
			p_meas = (k == 2) ? val : 16'h03E8;
		end
		@(negedge mclk);
		sample_en = 1'b0;
	endtask

	function automatic logic [W-1:0] lvl(input logic [1:0] s);
		case (s)
			SEL_OV: return ovt_level;
			SEL_UV: return uvt_level;
			SEL_OC: return oct_level;
			default: return opt_level;
		endcase
	endfunction

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	initial begin
		logic [W-1:0] r, e;
		{rst_b, sample_en, v_meas, i_meas, p_meas} = '0;
		reg_state_in = 4'h1;
		void'($urandom(95));
		idle(5);
		rst_b = 1'b1;
		idle(1);
		`CHK("status", ST_DISABLED, status)
		`CHK("ovt", TOP, ovt_level)
		`CHK("opt", TOP, opt_level)
		`CHK("uvt", 16'h0000, uvt_level)
		`CHK("ilk_en", ILK_EN_RST, ilk_enabled)
		$display("test reset done");
		for (int k = 0; k < 4; k++) begin
			reg_state_in = 4'h1 << k;
			idle(2);
			`CHK("reg_led", 4'h1 << k, reg_led)
			`CHK("reg_code", 2'(k), reg_code)
		end
		reg_state_in = 4'h3;
		idle(2);
		`CHK("reg_hold", 4'h8, reg_led)
		$display("test regulation done");
		for (int k = 0; k < 8; k++) begin
			r = (k < 4) ? ((k == 1) ? 16'h0001 : TOP + 16'h0001) : W'($urandom_range(65535, 1));
			e = (k % 4 == 1) ? ((r < UVMIN) ? UVMIN : r) : ((r > TOP) ? TOP : r);
			pm.thr(2'(k), r);
			`CHK("thr_level", e, lvl(2'(k)))
		end
		pm.thr(SEL_UV, 16'h0000);
		`CHK("uvt_zero", 16'h0000, uvt_level)
		pm.press(K_RESTORE, 1'b0);
		`CHK("ovt_def", TOP, ovt_level)
		`CHK("opt_def", TOP, opt_level)
		$display("test thresholds done");
		act(K_START, 1'b0, ST_ENABLED, 1'b1, -1);
		act(K_STOP, 1'b0, ST_DISABLED, 1'b0, -1);
		pm.thr(SEL_UV, 16'h07D0);
		v_meas = 16'h07D0;
		act(K_START, 1'b0, ST_SOFT, 1'b0, AL_UV);
		act(K_CLEAR, 1'b0, ST_DISABLED, 1'b0, -1);
		v_meas = 16'h1388;
		act(K_START, 1'b0, ST_ENABLED, 1'b1, -1);
		ev(ST_SOFT, 1'b0, AL_UV);
		samp(0, 16'h07D0, N);
		drain();
		act(K_CLEAR, 1'b0, ST_DISABLED, 1'b0, -1);
		pm.press(K_RESTORE, 1'b0);
		$display("test under_voltage done");
		for (int k = 0; k < 3; k++) begin
			samp(k, TOP - 16'h0001, 1);
			act(K_START, 1'b0, ST_ENABLED, 1'b1, -1);
			samp(k, TOP + 16'h0001, N - 1);
			samp(k, TOP, 1);
			samp(k, TOP + 16'h0001, N - 1);
			`CHK("no_trip", ST_ENABLED, status)
			ev(ST_SOFT, 1'b0, (k == 0) ? AL_OV : (k == 1) ? AL_OC : AL_OP);
			samp(k, TOP + 16'h0001, 1);
			drain();
			nop(K_CLEAR, 1'b0, ST_SOFT);
			samp(k, TOP, 1);
			act(K_CLEAR, 1'b0, ST_DISABLED, 1'b0, -1);
		end
		$display("test trips done");
		pm.ilk_cfg(1'b1);
		`CHK("ilk_en", 1'b1, ilk_enabled)
		act(K_START, 1'b0, ST_ENABLED, 1'b1, -1);
		ev(ST_SOFT, 1'b0, AL_ILK);
		pm.pins(1'b0, 1'b0, 1'b0);
		drain();
		nop(K_CLEAR, 1'b0, ST_SOFT);
		pm.pins(1'b1, 1'b0, 1'b0);
		idle(3);
		act(K_CLEAR, 1'b0, ST_DISABLED, 1'b0, -1);
		ev(ST_SOFT, 1'b0, AL_ILK);
		pm.pins(1'b0, 1'b0, 1'b0);
		drain();
		pm.pins(1'b1, 1'b0, 1'b0);
		idle(3);
		act(K_CLEAR, 1'b0, ST_DISABLED, 1'b0, -1);
		pm.press(K_RESTORE, 1'b0);
		`CHK("ilk_off", 1'b0, ilk_enabled)
		$display("test interlock done");
		pm.lk(1'b0, RANK_PANEL);
		`CHK("lock_led", 1'b1, lock_led)
		nop(K_START, 1'b1, ST_DISABLED);
		act(K_START, 1'b0, ST_ENABLED, 1'b1, -1);
		act(K_STOP, 1'b1, ST_DISABLED, 1'b0, -1);
		pm.lk(1'b0, RANK_SCPI);
		pm.lk(1'b1, RANK_PANEL);
		`CHK("rank", RANK_SCPI, lock_rank)
		pm.lk(1'b1, RANK_SCPI);
		`CHK("rank", RANK_NONE, lock_rank)
		pm.pins(1'b1, 1'b0, 1'b1);
		idle(4);
		pm.lk(1'b1, RANK_SCPI);
		`CHK("rank", RANK_DIN, lock_rank)
		pm.pins(1'b1, 1'b0, 1'b0);
		idle(4);
		`CHK("lock_led", 1'b0, lock_led)
		pm.lk(1'b0, RANK_DIN);
		pm.lk(1'b1, RANK_SCPI);
		`CHK("rank", RANK_DIN, lock_rank)
		pm.lk(1'b1, RANK_DIN);
		`CHK("rank", RANK_NONE, lock_rank)
		$display("test lock done");
		act(K_START, 1'b0, ST_ENABLED, 1'b1, -1);
		ev(ST_HARD, 1'b0, AL_TH);
		pm.pins(1'b1, 1'b1, 1'b0);
		drain();
		nop(K_START, 1'b0, ST_HARD);
		nop(K_CLEAR, 1'b0, ST_HARD);
		rst_b = 1'b0;
		idle(5);
		ev(ST_HARD, 1'b0, AL_TH);
		rst_b = 1'b1;
		drain();
		pm.pins(1'b1, 1'b0, 1'b0);
		rst_b = 1'b0;
		idle(5);
		rst_b = 1'b1;
		idle(4);
		`CHK("cold_start", ST_DISABLED, status)
		$display("test thermal done");
		give_verdict();
	end
endmodule
`default_nettype wire

// [testbench/load_partner_model.sv]
// Far side of the supervisor: front panel, host commands and user I/O pins.
// Assumes the bench calls one task at a time; everything moves on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module load_partner_model #(
	parameter int W = 16
) (
	// Clock
	input  wire logic         mclk,
	// Command pulses
	output logic              cmd_start,
	output logic              cmd_stop,
	output logic              cmd_clear,
	output logic              cmd_panel,
	output logic              factory_restore,
	// Configuration
	output logic              thr_wr,
	output logic [1:0]        thr_sel,
	output logic [W-1:0]      thr_val,
	output logic              ilk_en_wr,
	output logic              ilk_en_val,
	// Lock requests
	output logic              lock_req,
	output logic              unlock_req,
	output logic [1:0]        lock_src,
	// User I/O pins
	output logic              ilk_pin,
	output logic              therm_pin,
	output logic              lock_pin
);
	initial begin
		{cmd_start, cmd_stop, cmd_clear, cmd_panel, factory_restore} = 5'h00;
		{thr_wr, thr_sel, thr_val, ilk_en_wr, ilk_en_val} = '0;
		{lock_req, unlock_req, lock_src} = 4'h0;
		{ilk_pin, therm_pin, lock_pin} = 3'h4;
	end

	// Released qualifiers show the inverse of their last value, so nothing stale looks valid
	task automatic press(input logic [3:0] k, input logic pnl);
		@(negedge mclk);
		{factory_restore, cmd_clear, cmd_stop, cmd_start} = k;
		cmd_panel = pnl;
		@(negedge mclk);
		{factory_restore, cmd_clear, cmd_stop, cmd_start} = 4'h0;
		cmd_panel = ~pnl;
	endtask

	task automatic thr(input logic [1:0] s, input logic [W-1:0] v);
		@(negedge mclk);
		thr_wr = 1'b1;
		thr_sel = s;
		thr_val = v;
		@(negedge mclk);
		thr_wr = 1'b0;
		thr_sel = ~s;
		thr_val = ~v;
	endtask

	task automatic ilk_cfg(input logic en);
		@(negedge mclk);
		ilk_en_wr = 1'b1;
		ilk_en_val = en;
		@(negedge mclk);
		ilk_en_wr = 1'b0;
		ilk_en_val = ~en;
	endtask

	task automatic lk(input logic unl, input logic [1:0] src);
		@(negedge mclk);
		lock_req = ~unl;
		unlock_req = unl;
		lock_src = src;
		@(negedge mclk);
		lock_req = 1'b0;
		unlock_req = 1'b0;
		lock_src = ~src;
	endtask

	// Interlock is brought back high before each accepted clear; one clear is sent while it is low, to be refused
	task automatic pins(input logic ilk, input logic th, input logic lck);
		@(negedge mclk);
		{ilk_pin, therm_pin, lock_pin} = {ilk, th, lck};
	endtask
endmodule
`default_nettype wire

// [verilog/load_fault_supervisor.sv]
// Protection, fault latch and lock supervisor for an electronic DC load.
// Assumes commands and measurements arrive on mclk; the interlock, thermal and
// lock pins are asynchronous and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Exactly one regulation state is shown on the LEDs and as a code.
// - Over-voltage threshold is clamped to 110% of voltage full scale.
// - A trip needs N_TRIP consecutive out-of-range samples, 4 by default.
// - Over-voltage trip opens the switch, latches a soft fault, raises its alarm.
// - Over-voltage clear needs voltage at or below threshold, then clear, then start.
// - Factory defaults put the over-voltage threshold at 110% of rating.
// - Under-voltage threshold is at least 5% of full scale, or zero.
// - Starting with voltage at or below an active under-voltage threshold trips at once.
// - Under-voltage trip opens the switch and alarms; clear then start recovers.
// - Under-voltage default is zero, and zero disables that protection.
// - Over-current threshold is clamped to 110% of current full scale.
// - Over-current clear needs current at or below threshold, then clear, then start.
// - Over-power threshold is clamped to 110% of power full scale.
// - Over-power clear needs power at or below threshold, then clear, then start.
// - Factory defaults put the over-power threshold at 110% of rating.
// - Thermal fault is a hard fault: switch open, all starts refused.
// - Only reset clears the hard fault; a persisting hot sensor re-trips.
// - Enabled interlock losing its high level opens the switch as soft fault.
// - Interlock is off after defaults; panel or host commands enable it.
// - Interlock clear is accepted only once the interlock input is high again.
// - While locked, panel start, clear and configuration writes are ignored; stop and factory restore still act; lock LED lit.
// - Lock ranks: digital input over host over panel; unlock needs equal or higher rank.
// - Clear releases soft faults to disabled and leaves hard faults alone.
// - Start closes the switch and enables when no fault is latched.
module load_fault_supervisor #(
	parameter int W     = 16,
	parameter int N_TRIP = load_prot_pkg::TRIP_SAMPLES_DEF,
	parameter int V_FS  = 30000,
	parameter int I_FS  = 30000,
	parameter int P_FS  = 30000
) (
	// Clock and reset
	input  wire logic            mclk,
	input  wire logic            rst_b,
	// Measurement path
	input  wire logic            sample_en,
	input  wire logic [W-1:0]    v_meas,
	input  wire logic [W-1:0]    i_meas,
	input  wire logic [W-1:0]    p_meas,
	input  wire logic [3:0]      reg_state_in,
	// Asynchronous pins
	input  wire logic            ilk_pin,
	input  wire logic            therm_pin,
	input  wire logic            lock_pin,
	// Commands, cmd_panel marks a front-panel origin
	input  wire logic            cmd_start,
	input  wire logic            cmd_stop,
	input  wire logic            cmd_clear,
	input  wire logic            cmd_panel,
	input  wire logic            factory_restore,
	// Configuration writes
	input  wire logic            thr_wr,
	input  wire logic [1:0]      thr_sel,
	input  wire logic [W-1:0]    thr_val,
	input  wire logic            ilk_en_wr,
	input  wire logic            ilk_en_val,
	// Lock requests from panel or host
	input  wire logic            lock_req,
	input  wire logic            unlock_req,
	input  wire logic [1:0]      lock_src,
	// Status
	output logic                 input_switch_on,
	output load_prot_pkg::status_t status,
	output logic                 ov_alarm,
	output logic                 uv_alarm,
	output logic                 oc_alarm,
	output logic                 op_alarm,
	output logic                 ilk_alarm,
	output logic                 therm_alarm,
	output logic                 lock_led,
	output logic [1:0]           lock_rank,
	output logic                 ilk_enabled,
	output logic [3:0]           reg_led,
	output logic [1:0]           reg_code,
	// Threshold readback
	output logic [W-1:0]         ovt_level,
	output logic [W-1:0]         uvt_level,
	output logic [W-1:0]         oct_level,
	output logic [W-1:0]         opt_level
);
	import load_prot_pkg::*;

	localparam logic [W-1:0] OV_LIM = W'(V_FS * TRIP_LIMIT_PCT / 100);
	localparam logic [W-1:0] OC_LIM = W'(I_FS * TRIP_LIMIT_PCT / 100);
	localparam logic [W-1:0] OP_LIM = W'(P_FS * TRIP_LIMIT_PCT / 100);
	localparam logic [W-1:0] UV_MIN = W'((V_FS * UV_MIN_PCT + 99) / 100);

	function automatic logic [W-1:0] clamp_hi(input logic [W-1:0] v, input logic [W-1:0] lim);
		clamp_hi = (v > lim) ? lim : v;
	endfunction

	function automatic logic is_onehot4(input logic [3:0] x);
		is_onehot4 = (x != 4'h0) && ((x & (x - 4'h1)) == 4'h0);
	endfunction

	function automatic logic [1:0] enc4(input logic [3:0] x);
		enc4 = {x[3] | x[2], x[3] | x[1]};
	endfunction

	// Pin synchronisers: bit 0 interlock, 1 thermal, 2 lock
	logic [2:0] sync1_q, sync2_q;
	logic       lock_pin_q;
	logic       ilk_s, therm_s, lockp_s;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sync1_q    <= SYNC_RST;
			sync2_q    <= SYNC_RST;
			lock_pin_q <= 1'b0;
		end else begin
			sync1_q    <= {lock_pin, therm_pin, ilk_pin};
			sync2_q    <= sync1_q;
			lock_pin_q <= sync2_q[2];
		end
	end
	assign ilk_s   = sync2_q[0];
	assign therm_s = sync2_q[1];
	assign lockp_s = sync2_q[2];

	// Trip comparators
	logic [W-1:0] ovt_q, uvt_q, oct_q, opt_q, ovt_d, uvt_d, oct_d, opt_d;
	logic         ov_trip, uv_trip, oc_trip, op_trip;
	logic         ov_oor, oc_oor, op_oor;

	trip_filter #(.W(W), .N(N_TRIP)) u_ov (.mclk(mclk), .rst_b(rst_b), .sample_en(sample_en),
		.meas(v_meas), .thresh(ovt_q), .is_under(1'b0), .arm(1'b1),
		.trip_q(ov_trip), .oor_q(ov_oor));
	trip_filter #(.W(W), .N(N_TRIP)) u_uv (.mclk(mclk), .rst_b(rst_b), .sample_en(sample_en),
		.meas(v_meas), .thresh(uvt_q), .is_under(1'b1), .arm(uvt_q != '0),
		.trip_q(uv_trip), .oor_q());
	trip_filter #(.W(W), .N(N_TRIP)) u_oc (.mclk(mclk), .rst_b(rst_b), .sample_en(sample_en),
		.meas(i_meas), .thresh(oct_q), .is_under(1'b0), .arm(1'b1),
		.trip_q(oc_trip), .oor_q(oc_oor));
	trip_filter #(.W(W), .N(N_TRIP)) u_op (.mclk(mclk), .rst_b(rst_b), .sample_en(sample_en),
		.meas(p_meas), .thresh(opt_q), .is_under(1'b0), .arm(1'b1),
		.trip_q(op_trip), .oor_q(op_oor));

	// Lock and configuration
	logic [1:0] lock_q, lock_d;
	logic       ilk_en_q, ilk_en_d;
	logic       locked, panel_ok;

	assign locked   = (lock_q != RANK_NONE);
	assign panel_ok = !(cmd_panel && locked);

	always_comb begin
		lock_d   = lock_q;
		ilk_en_d = ilk_en_q;
		ovt_d    = ovt_q;
		uvt_d    = uvt_q;
		oct_d    = oct_q;
		opt_d    = opt_q;
		if (lockp_s && !lock_pin_q)
			lock_d = RANK_DIN;
		else if (!lockp_s && lock_pin_q)
			lock_d = RANK_NONE;
		else if (lock_req && lock_src > lock_q)
			lock_d = lock_src;
		else if (unlock_req && lock_src >= lock_q)
			lock_d = RANK_NONE;
		if (factory_restore) begin
			ovt_d    = OV_LIM;
			uvt_d    = '0;
			oct_d    = OC_LIM;
			opt_d    = OP_LIM;
			ilk_en_d = ILK_EN_RST;
		end else begin
			if (ilk_en_wr && panel_ok)
				ilk_en_d = ilk_en_val;
			if (thr_wr && panel_ok) begin
				unique case (thr_sel)
					SEL_OV: ovt_d = clamp_hi(thr_val, OV_LIM);
					SEL_UV: uvt_d = (thr_val != '0 && thr_val < UV_MIN) ? UV_MIN : thr_val;
					SEL_OC: oct_d = clamp_hi(thr_val, OC_LIM);
					SEL_OP: opt_d = clamp_hi(thr_val, OP_LIM);
				endcase
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			lock_q   <= RANK_NONE;
			ilk_en_q <= ILK_EN_RST;
			ovt_q    <= OV_LIM;
			uvt_q    <= '0;
			oct_q    <= OC_LIM;
			opt_q    <= OP_LIM;
		end else begin
			lock_q   <= lock_d;
			ilk_en_q <= ilk_en_d;
			ovt_q    <= ovt_d;
			uvt_q    <= uvt_d;
			oct_q    <= oct_d;
			opt_q    <= opt_d;
		end
	end

	// Fault and enable state
	status_t         st_q, st_d;
	logic            sw_q, sw_d;
	logic [AL_N-1:0] al_q, al_d;
	logic            ilk_loss, uv_now, start_ok, clear_ok, any_trip;

	assign ilk_loss = ilk_en_q && !ilk_s;
	assign uv_now   = (uvt_q != '0) && (v_meas <= uvt_q);
	assign start_ok = cmd_start && panel_ok;
	assign any_trip = ov_trip || uv_trip || oc_trip || op_trip;
	// Every latched cause except under-voltage must have gone away first, so a clear never re-arms into a fault
	assign clear_ok = cmd_clear && panel_ok
		&& !(al_q[AL_OV] && ov_oor)
		&& !(al_q[AL_OC] && oc_oor)
		&& !(al_q[AL_OP] && op_oor)
		&& !(al_q[AL_ILK] && !ilk_s);

	always_comb begin
		st_d = st_q;
		sw_d = sw_q;
		al_d = al_q;
		// Thermal wins over everything; only reset leaves the hard state
		if (therm_s && st_q != ST_HARD) begin
			st_d        = ST_HARD;
			sw_d        = 1'b0;
			al_d[AL_TH] = 1'b1;
		end else begin
			unique case (st_q)
				ST_DISABLED: begin
					if (ilk_loss) begin
						st_d         = ST_SOFT;
						al_d[AL_ILK] = 1'b1;
					end else if (start_ok && uv_now) begin
						st_d        = ST_SOFT;
						al_d[AL_UV] = 1'b1;
					end else if (start_ok) begin
						st_d = ST_ENABLED;
						sw_d = 1'b1;
					end
				end
				ST_ENABLED: begin
					// A fault in the same cycle as stop is still reported
					if (ilk_loss || any_trip) begin
						st_d         = ST_SOFT;
						sw_d         = 1'b0;
						al_d[AL_OV]  = ov_trip;
						al_d[AL_UV]  = uv_trip;
						al_d[AL_OC]  = oc_trip;
						al_d[AL_OP]  = op_trip;
						al_d[AL_ILK] = ilk_loss;
					end else if (cmd_stop) begin
						st_d = ST_DISABLED;
						sw_d = 1'b0;
					end
				end
				ST_SOFT: begin
					if (clear_ok) begin
						st_d = ST_DISABLED;
						al_d = '0;
					end
				end
				ST_HARD: begin
					sw_d = 1'b0;
				end
				default: begin
					st_d = ST_DISABLED;
					sw_d = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= ST_DISABLED;
			sw_q <= 1'b0;
			al_q <= '0;
		end else begin
			st_q <= st_d;
			sw_q <= sw_d;
			al_q <= al_d;
		end
	end

	// Regulation report: an illegal loop code keeps the last good one
	// Code is registered beside the LEDs so the output comes from a flop
	localparam logic [1:0] REG_CODE_RST = enc4(REG_LED_RST);
	logic [3:0] led_q, led_d;
	logic [1:0] code_q, code_d;
	logic       lock_led_q, lock_led_d;

	always_comb begin
		led_d      = is_onehot4(reg_state_in) ? reg_state_in : led_q;
		code_d     = enc4(led_d);
		lock_led_d = (lock_d != RANK_NONE);
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			led_q      <= REG_LED_RST;
			code_q     <= REG_CODE_RST;
			lock_led_q <= 1'b0;
		end else begin
			led_q      <= led_d;
			code_q     <= code_d;
			lock_led_q <= lock_led_d;
		end
	end

	assign input_switch_on = sw_q;
	assign status          = st_q;
	assign ov_alarm        = al_q[AL_OV];
	assign uv_alarm        = al_q[AL_UV];
	assign oc_alarm        = al_q[AL_OC];
	assign op_alarm        = al_q[AL_OP];
	assign ilk_alarm       = al_q[AL_ILK];
	assign therm_alarm     = al_q[AL_TH];
	assign lock_led        = lock_led_q;
	assign lock_rank       = lock_q;
	assign ilk_enabled     = ilk_en_q;
	assign reg_led         = led_q;
	assign reg_code        = code_q;
	assign ovt_level       = ovt_q;
	assign uvt_level       = uvt_q;
	assign oct_level       = oct_q;
	assign opt_level       = opt_q;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	a_reg_onehot: assert property ($onehot(led_q) && reg_code == enc4(led_q))
		else $error("regulation report not one-hot");
	a_thr_limits: assert property (ovt_q <= OV_LIM && oct_q <= OC_LIM && opt_q <= OP_LIM)
		else $error("threshold above 110 percent of full scale");
	a_uv_floor: assert property (uvt_q == '0 || uvt_q >= UV_MIN)
		else $error("under-voltage threshold below the floor");
	a_ov_opens: assert property ($rose(al_q[AL_OV]) |-> !sw_q && st_q == ST_SOFT)
		else $error("over-voltage alarm without open switch");
	a_clear_held: assert property (st_q == ST_SOFT && al_q[AL_OV] && ov_oor && !therm_s
		|=> st_q == ST_SOFT)
		else $error("clear accepted while voltage still high");
	a_uv_instant: assert property (st_q == ST_DISABLED && start_ok && uv_now && !ilk_loss
		&& !therm_s |=> st_q == ST_SOFT && al_q[AL_UV] && !sw_q)
		else $error("start below under-voltage threshold not tripped");
	a_hard_sticks: assert property (st_q == ST_HARD |=> st_q == ST_HARD && !sw_q)
		else $error("hard fault left or switch closed");
	a_therm_trip: assert property (therm_s |=> st_q == ST_HARD && al_q[AL_TH])
		else $error("thermal fault not taken");
	a_ilk_trip: assert property (ilk_en_q && !ilk_s && st_q == ST_ENABLED && !therm_s
		|=> st_q == ST_SOFT && !sw_q && al_q[AL_ILK])
		else $error("interlock loss did not trip");
	a_switch_cause: assert property ($rose(sw_q) |-> $past(st_q) == ST_DISABLED
		&& $past(cmd_start) && st_q == ST_ENABLED)
		else $error("switch closed without start");
	a_panel_locked: assert property (locked && cmd_panel && cmd_start && st_q == ST_DISABLED
		|=> !sw_q)
		else $error("panel start acted while locked");
	a_din_rank: assert property (lock_q == RANK_DIN && lockp_s && lock_pin_q
		|=> lock_q == RANK_DIN)
		else $error("digital input lock released by lower rank");
	a_lock_led: assert property (lock_led_q == locked)
		else $error("lock indicator disagrees with lock state");

	c_ov_trip: cover property ($rose(al_q[AL_OV]));
	c_recover: cover property (st_q == ST_SOFT ##1 st_q == ST_DISABLED ##[1:20] sw_q);
	c_thermal: cover property ($rose(st_q == ST_HARD));
	c_din_lock: cover property (lock_q == RANK_DIN ##1 unlock_req && lock_src == RANK_SCPI);

endmodule
`default_nettype wire

// [verilog/trip_filter.sv]
// Sample-debounced threshold comparator for one measured quantity.
// Assumes meas is stable whenever sample_en pulses; same clock as the supervisor.
`timescale 1ns/1ps
`default_nettype none
module trip_filter #(
	parameter int W = 16,
	parameter int N = load_prot_pkg::TRIP_SAMPLES_DEF
) (
	// Clock and reset
	input  wire logic         mclk,
	input  wire logic         rst_b,
	// Sample and threshold
	input  wire logic         sample_en,
	input  wire logic [W-1:0] meas,
	input  wire logic [W-1:0] thresh,
	input  wire logic         is_under,
	input  wire logic         arm,
	// Result
	output logic              trip_q,
	output logic              oor_q
);
	import load_prot_pkg::*;

	localparam int CW = $clog2(N + 1);
	localparam logic [CW-1:0] CNT_MAX = CW'(N);

	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic          oor_now;
	logic          oor_d;
	logic          trip_d;

	always_comb begin
		oor_now = arm && (is_under ? (meas <= thresh) : (meas > thresh));
		cnt_d   = cnt_q;
		oor_d   = oor_q;
		if (sample_en) begin
			oor_d = oor_now;
			// Any in-range sample restarts the run
			if (!oor_now)
				cnt_d = '0;
			else if (cnt_q != CNT_MAX)
				cnt_d = cnt_q + CW'(1);
		end
		if (!arm)
			cnt_d = '0;
		trip_d = (cnt_d == CNT_MAX);
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q  <= '0;
			oor_q  <= 1'b0;
			trip_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			oor_q  <= oor_d;
			trip_q <= trip_d;
		end
	end

	a_trip_needs_run: assert property (@(posedge mclk) disable iff (!rst_b)
		$rose(trip_q) |-> $past(cnt_q) == CNT_MAX - CW'(1) && $past(sample_en))
		else $error("trip without a full run of samples");
	a_inrange_resets: assert property (@(posedge mclk) disable iff (!rst_b)
		sample_en && !oor_now |=> cnt_q == '0 && !trip_q)
		else $error("in-range sample did not restart the count");

endmodule
`default_nettype wire
